//--- rtl/usb_irq_pkg.sv
// Purpose: Shared constants and types for the USB function interrupt flag block.
// Assumes: Byte-wide indexed register port, one device clock.
// Notes:   Offsets are register indices on the internal register port.
package usb_irq_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] ADDR_IN_FLAGS   = 8'h02;
  localparam logic [7:0] ADDR_OUT_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_CM_FLAGS   = 8'h06;
  localparam logic [7:0] ADDR_IN_EN      = 8'h07;
  localparam logic [7:0] ADDR_OUT_EN     = 8'h09;
  localparam logic [7:0] ADDR_CM_EN      = 8'h0B;
  localparam logic [7:0] ADDR_CTRL       = 8'h0C;

  // Reset values of the enable registers.
  localparam logic [3:0] RST_IN_EN       = 4'hF;
  localparam logic [3:0] RST_OUT_EN      = 4'hE;
  localparam logic [3:0] RST_CM_EN       = 4'h6;

  // Implemented bits of each register.
  localparam logic [3:0] MASK_IN         = 4'hF;
  localparam logic [3:0] MASK_OUT        = 4'hE;
  localparam logic [3:0] MASK_CM         = 4'hF;

  // Field positions in the common registers.
  localparam int         BIT_SUSPEND     = 0;
  localparam int         BIT_RESUME      = 1;
  localparam int         BIT_BUS_RESET   = 2;
  localparam int         BIT_FRAME       = 3;
  localparam int         BIT_SUSP_DET    = 0;

  // Frame timing: one frame lasts 1 ms.
  localparam int         FRAME_US        = 1000;
  localparam int         CLK_MHZ         = 125;
  localparam int         FRAME_CYCLES    = FRAME_US * CLK_MHZ;

  // Packet completion event from the serial engine.
  typedef struct packed {
    logic       valid;    // One-cycle completion pulse.
    logic       is_in;    // High for transmission, low for reception.
    logic [1:0] ep;       // Endpoint number 0 to 3.
    logic       crc_ok;   // Packet arrived free of errors.
    logic       hs_ack;   // Host handshake received (transmission).
  } pkt_evt_s;

  // Bus signalling events from the line-state detector.
  typedef struct packed {
    logic sof;            // Start-of-frame token received intact.
    logic bus_reset;      // Reset signalling detected.
    logic resume;         // Resume signalling detected.
    logic suspend;        // Suspend signalling detected.
  } bus_evt_s;

endpackage : usb_irq_pkg

//--- rtl/usb_function_irq_flags.sv
// Purpose: Interrupt flags, enables and request of a USB function controller.
// Assumes: Events are synchronous pulses on clk_sys_i from the serial engine.
// Notes:   Flag registers clear on read; a coincident event survives the clear.
//
// Strobed register access was left to the implementer.

// Notes on behaviour
// - OUT flags in bits one to three.
// - Reading OUT flags returns then clears them.
// - Frame-start flag bit three on token.
// - Own frame timer synthesises missed frame starts.
// - Bus-reset flag bit two on reset.
// - Resume flag only while suspended.
// - Suspend flag only with detection enabled.
// - Reading common flags returns then clears them.
// - IN enables bits zero to three, reset 0x0F.
// - OUT enables bits one to three, reset 0x0E.
// - Common enables bits three..zero, reset 0x06.
// - Upper bits read zero, writes ignored.
// - Engine handles handshakes without software.
// - Receive flag only after complete packet.
// - Transmit flag only after host handshake.
// - Corrupted packets set no flag.
// - IN flags bits zero to three, clear-on-read.
// - Request asserted while any enabled flag set.
// - Bus reset enables all but suspend, clears flags.
// - Suspend ignored while detection disabled.
module usb_function_irq_flags
  import usb_irq_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES  // Cycles per frame for synthesised frame starts.
) (
  input  wire logic       clk_sys_i,      // Device clock, 125 MHz.
  input  wire logic       rst_i,          // Asynchronous reset, active high.
  input  wire logic [7:0] addr_i,         // Register offset.
  input  wire logic [7:0] wdata_i,        // Write data.
  input  wire logic       wr_i,           // Write strobe.
  input  wire logic       rd_i,           // Read strobe.
  output logic      [7:0] rdata_o,        // Read data, valid the cycle after rd_i.
  input  wire pkt_evt_s   pkt_i,          // Packet completion events.
  input  wire bus_evt_s   bus_i,          // Bus signalling events.
  output logic            suspended_o,    // Function is in suspend mode.
  output logic            handshake_o,    // Engine sends handshake for good received packet.
  output logic            irq_o           // Function-level interrupt request.
);

  // Flag, enable and control state.
  logic [3:0]  in_flags_r,  in_flags_nxt;    // IN endpoint flags.
  logic [3:0]  out_flags_r, out_flags_nxt;   // OUT endpoint flags.
  logic [3:0]  cm_flags_r,  cm_flags_nxt;    // Common flags.
  logic [3:0]  in_en_r,     in_en_nxt;       // IN endpoint enables.
  logic [3:0]  out_en_r,    out_en_nxt;      // OUT endpoint enables.
  logic [3:0]  cm_en_r,     cm_en_nxt;       // Common enables.
  logic        susp_det_r,  susp_det_nxt;    // Suspend detection enable.
  logic        susp_r,      susp_nxt;        // Suspend mode.
  logic [7:0]  rdata_r,     rdata_nxt;       // Registered read data.
  logic        hs_r,        hs_nxt;          // Handshake pulse.
  logic [31:0] frame_cnt_r, frame_cnt_nxt;   // Frame timer.

  // Qualified event strobes.
  logic [3:0]  in_set;                       // IN flag set requests.
  logic [3:0]  out_set;                      // OUT flag set requests.
  logic [3:0]  cm_set;                       // Common flag set requests.
  logic        frame_tick;                   // Frame start, real or synthesised.
  logic        pkt_good;                     // Error-free packet event.

  // Decode packet events; erroneous packets are dropped and transmit needs the handshake.
  // The engine reports a packet only once it has ended, so a partial packet
  // never reaches this decode; the crc bit then decides whether it counts.
  always_comb begin
    pkt_good = pkt_i.valid && pkt_i.crc_ok;
    in_set   = 4'h0;
    out_set  = 4'h0;
    // A sent packet counts only once the host has acknowledged it.
    if (pkt_good && pkt_i.is_in && pkt_i.hs_ack) begin
      in_set[pkt_i.ep] = 1'b1;
    end else if (pkt_good && !pkt_i.is_in) begin
      // Endpoint 0 reports both directions in the IN register.
      if (pkt_i.ep == 2'd0) begin
        in_set[0] = 1'b1;
      end else begin
        out_set[pkt_i.ep] = 1'b1;
      end
    end
  end

  // Frame timer restarts on each received token and ticks if one is missed.
  // Restarting on the token keeps the timer aligned to the host's frames,
  // so while tokens come at most FRAME_LEN cycles apart the timer itself never ticks.
  // A late token simply restarts the count; the timer is only the fallback.
  always_comb begin
    frame_tick    = 1'b0;
    frame_cnt_nxt = frame_cnt_r + 32'd1;
    if (bus_i.sof) begin
      frame_tick    = 1'b1;
      frame_cnt_nxt = 32'd0;
    end else if (frame_cnt_r >= 32'(FRAME_LEN - 1)) begin
      frame_tick    = 1'b1;
      frame_cnt_nxt = 32'd0;
    end
    // Timer is held at zero and frame ticks are dropped while suspended.
    // No tokens come in suspend, so ticking here would only give false flags.
    if (susp_r) begin
      frame_tick    = 1'b0;
      frame_cnt_nxt = 32'd0;
    end
  end

  // Common event qualification.
  // Resume counts only in suspend, suspend only with detection on; other
  // signalling is dropped here and leaves neither flag nor mode behind.
  always_comb begin
    cm_set                = 4'h0;
    cm_set[BIT_FRAME]     = frame_tick;
    cm_set[BIT_BUS_RESET] = bus_i.bus_reset;
    cm_set[BIT_RESUME]    = bus_i.resume && susp_r;
    cm_set[BIT_SUSPEND]   = bus_i.suspend && susp_det_r;
  end

  // Next state of flags, enables, suspend and read data.
  always_comb begin
    in_flags_nxt  = in_flags_r;
    out_flags_nxt = out_flags_r;
    cm_flags_nxt  = cm_flags_r;
    in_en_nxt     = in_en_r;
    out_en_nxt    = out_en_r;
    cm_en_nxt     = cm_en_r;
    susp_det_nxt  = susp_det_r;
    susp_nxt      = susp_r;
    rdata_nxt     = 8'h00;
    hs_nxt        = pkt_good && !pkt_i.is_in;

    // Read returns current value; clearing reads zero the register.
    // Read data take the value before the clear, so each flag is seen once;
    // an event in the same cycle is merged back in below for the next read.
    if (rd_i) begin
      unique case (addr_i)
        ADDR_IN_FLAGS: begin
          rdata_nxt    = {4'h0, in_flags_r};
          in_flags_nxt = 4'h0;
        end
        ADDR_OUT_FLAGS: begin
          rdata_nxt     = {4'h0, out_flags_r};
          out_flags_nxt = 4'h0;
        end
        ADDR_CM_FLAGS: begin
          rdata_nxt    = {4'h0, cm_flags_r};
          cm_flags_nxt = 4'h0;
          // Reading after a resume leaves suspend mode.
          if (cm_flags_r[BIT_RESUME]) begin
            susp_nxt = 1'b0;
          end
        end
        ADDR_IN_EN:  rdata_nxt = {4'h0, in_en_r};
        ADDR_OUT_EN: rdata_nxt = {4'h0, out_en_r};
        ADDR_CM_EN:  rdata_nxt = {4'h0, cm_en_r};
        ADDR_CTRL:   rdata_nxt = {6'h00, susp_r, susp_det_r};
        default:     rdata_nxt = 8'h00;                      // Unmapped reads zero.
      endcase
    end

    // Writes store only implemented bits.
    // Flag registers are read only; writes to them fall into the default arm.
    if (wr_i) begin
      unique case (addr_i)
        ADDR_IN_EN:  in_en_nxt    = wdata_i[3:0] & MASK_IN;
        ADDR_OUT_EN: out_en_nxt   = wdata_i[3:0] & MASK_OUT;
        ADDR_CM_EN:  cm_en_nxt    = wdata_i[3:0] & MASK_CM;
        ADDR_CTRL:   susp_det_nxt = wdata_i[BIT_SUSP_DET];
        default:     ;                                       // Other writes ignored.
      endcase
    end

    // Suspend entry and exit.
    // Exit is written after entry, so resume or bus reset in one cycle wins;
    // the function never stays suspended across reset signalling.
    if (cm_set[BIT_SUSPEND]) begin
      susp_nxt = 1'b1;
    end
    if (bus_i.resume || bus_i.bus_reset) begin
      susp_nxt = 1'b0;
    end

    // Bus reset re-arms enables except suspend and clears flags.
    // Suspend detection belongs to software and is left as it was; the
    // suspend interrupt stays disabled until software turns it on again.
    if (bus_i.bus_reset) begin
      in_en_nxt     = MASK_IN;
      out_en_nxt    = MASK_OUT;
      cm_en_nxt     = MASK_CM & ~(4'h1 << BIT_SUSPEND);
      in_flags_nxt  = 4'h0;
      out_flags_nxt = 4'h0;
      cm_flags_nxt  = 4'h0;
    end

    // New events win over any clear; flags record regardless of enables.
    // Merging last means neither a clearing read nor a bus reset can swallow
    // an event of the same cycle; the bus reset flag survives this way too.
    in_flags_nxt  = in_flags_nxt  | in_set;
    out_flags_nxt = out_flags_nxt | (out_set & MASK_OUT);
    cm_flags_nxt  = cm_flags_nxt  | cm_set;
  end

  // State registers.
  // The reset branch loads constants only, so release is clean on any edge.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      in_flags_r  <= 4'h0;
      out_flags_r <= 4'h0;
      cm_flags_r  <= 4'h0;
      in_en_r     <= RST_IN_EN;
      out_en_r    <= RST_OUT_EN;
      cm_en_r     <= RST_CM_EN;
      susp_det_r  <= 1'b0;
      susp_r      <= 1'b0;
      rdata_r     <= 8'h00;
      hs_r        <= 1'b0;
    end else begin
      in_flags_r  <= in_flags_nxt;
      out_flags_r <= out_flags_nxt;
      cm_flags_r  <= cm_flags_nxt;
      in_en_r     <= in_en_nxt;
      out_en_r    <= out_en_nxt;
      cm_en_r     <= cm_en_nxt;
      susp_det_r  <= susp_det_nxt;
      susp_r      <= susp_nxt;
      rdata_r     <= rdata_nxt;
      hs_r        <= hs_nxt;
    end
  end

  // Frame timer register, kept apart from the flag state it feeds.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      frame_cnt_r <= 32'd0;
    end else begin
      frame_cnt_r <= frame_cnt_nxt;
    end
  end

  // Outputs; request is the OR of enabled flags.
  // The request uses registered flags and enables only, so it is glitch
  // free and rises in the cycle that the flag becomes visible to software.
  assign irq_o       = |((in_flags_r & in_en_r) | (out_flags_r & out_en_r) | (cm_flags_r & cm_en_r));
  assign rdata_o     = rdata_r;
  assign suspended_o = susp_r;
  assign handshake_o = hs_r;

  // Checks on register and event behaviour. Antecedents leave out the
  // coincident events that the set-wins merge lets through, so a failure
  // points at the logic that the label names.

  // Clearing read of OUT flags zeroes them unless a new event arrives.
  a_out_clear_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_OUT_FLAGS && !pkt_i.valid && !bus_i.bus_reset) |=> (out_flags_r == 4'h0))
    else $error("OUT flags not cleared by read");

  // Read data returns pre-read OUT flags.
  a_out_read_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_OUT_FLAGS) |=> (rdata_o == {4'h0, $past(out_flags_r)} && rdata_o[0] == 1'b0))
    else $error("OUT flag read data wrong");

  // Common read clears all flags absent new events.
  a_cm_clear_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_CM_FLAGS && cm_set == 4'h0) |=> (cm_flags_r == 4'h0))
    else $error("common flags not cleared by read");

  // Received token sets frame flag.
  a_frame_token: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.sof && !susp_r) |=> cm_flags_r[BIT_FRAME])
    else $error("frame flag missing after token");

  // Frame flag appears within a frame even with no token.
  a_frame_synth: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (frame_cnt_r == 32'(FRAME_LEN - 1) && !susp_r) |=> cm_flags_r[BIT_FRAME])
    else $error("frame flag not synthesised");

  // Bus reset sets its flag.
  a_reset_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    bus_i.bus_reset |=> cm_flags_r[BIT_BUS_RESET])
    else $error("bus reset flag missing");

  // Resume flag never sets while not suspended.
  a_resume_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!cm_flags_r[BIT_RESUME] && !susp_r) |=> !cm_flags_r[BIT_RESUME])
    else $error("resume flag set outside suspend");

  // Suspend is ignored without detection enable.
  a_suspend_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!susp_det_r && !susp_r && !cm_flags_r[BIT_SUSPEND]) |=> (!susp_r && !cm_flags_r[BIT_SUSPEND]))
    else $error("suspend acted on while detection disabled");

  // Bus reset re-arms enables.
  a_reset_enables: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    bus_i.bus_reset |=> (in_en_r == 4'hF && out_en_r == 4'hE && cm_en_r == 4'hE))
    else $error("enables not re-armed by bus reset");

  // Corrupted packet sets no endpoint flag.
  a_bad_packet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pkt_i.valid && !pkt_i.crc_ok && !rd_i && !bus_i.bus_reset) |=>
      (in_flags_r == $past(in_flags_r) && out_flags_r == $past(out_flags_r)))
    else $error("corrupted packet set a flag");

  // Transmit flag requires host handshake.
  a_tx_handshake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pkt_i.valid && pkt_i.is_in && !pkt_i.hs_ack && !in_flags_r[pkt_i.ep]) |=> !in_flags_r[$past(pkt_i.ep)])
    else $error("IN flag set without handshake");

  // Event during clearing read stays pending.
  a_set_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_CM_FLAGS && bus_i.bus_reset) |=> cm_flags_r[BIT_BUS_RESET])
    else $error("event lost on clearing read");

  // Request follows enabled flags.
  a_irq_map: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (cm_flags_r[BIT_BUS_RESET] && cm_en_r[BIT_BUS_RESET]) |-> irq_o)
    else $error("request missing for enabled flag");

  // Upper bits always read zero.
  a_upper_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(rd_i) |-> (rdata_o[7:4] == 4'h0))
    else $error("upper bits read nonzero");

  // Clearing read of IN flags zeroes them unless a new event arrives.
  a_in_clear_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_IN_FLAGS && !pkt_i.valid && !bus_i.bus_reset) |=> (in_flags_r == 4'h0))
    else $error("IN flags not cleared by read");

  // A good received packet on endpoints 1 to 3 marks its OUT flag.
  a_rx_complete: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pkt_i.valid && pkt_i.crc_ok && !pkt_i.is_in && pkt_i.ep != 2'd0) |=> out_flags_r[$past(pkt_i.ep)])
    else $error("OUT flag missing after good packet");

  // An acknowledged sent packet marks its IN flag.
  a_tx_complete: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pkt_i.valid && pkt_i.crc_ok && pkt_i.is_in && pkt_i.hs_ack) |=> in_flags_r[$past(pkt_i.ep)])
    else $error("IN flag missing after acknowledged send");

  // A good received packet is answered by the engine alone.
  a_auto_handshake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pkt_i.valid && pkt_i.crc_ok && !pkt_i.is_in) |=> handshake_o)
    else $error("handshake missing after good packet");

  // A corrupted packet draws no handshake.
  a_bad_no_handshake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pkt_i.valid && !pkt_i.crc_ok) |=> !handshake_o)
    else $error("handshake sent for corrupted packet");

  // Bit 0 of the OUT enables never reads back as one.
  a_out_en_bit0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_OUT_EN) |=> (rdata_o[0] == 1'b0))
    else $error("OUT enable bit 0 read as one");

  // Suspend with detection enabled enters suspend and flags it.
  a_suspend_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_i.suspend && susp_det_r && !bus_i.resume && !bus_i.bus_reset) |=> (susp_r && cm_flags_r[BIT_SUSPEND]))
    else $error("suspend not entered with detection enabled");

  // IN enable writes land as written.
  a_in_en_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == ADDR_IN_EN && !bus_i.bus_reset) |=> (in_en_r == $past(wdata_i[3:0])))
    else $error("IN enables not written");

  // Common enable writes land as written.
  a_cm_en_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == ADDR_CM_EN && !bus_i.bus_reset) |=> (cm_en_r == $past(wdata_i[3:0])))
    else $error("common enables not written");

  // No request while every flag is clear or masked.
  a_irq_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ((in_flags_r & in_en_r) == 4'h0 && (out_flags_r & out_en_r) == 4'h0 &&
     (cm_flags_r & cm_en_r) == 4'h0) |-> !irq_o)
    else $error("request without enabled flag");

  // Any enabled endpoint flag raises the request.
  a_irq_endpoint: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ((in_flags_r & in_en_r) != 4'h0 || (out_flags_r & out_en_r) != 4'h0) |-> irq_o)
    else $error("request missing for endpoint flag");

endmodule : usb_function_irq_flags

//--- sim/usb_host_model.sv
// Purpose: Far-side model that turns bench commands into serial engine event pulses.
// Assumes: The bench holds go_i high for exactly one clock cycle per event.
// Notes:   Combinational, so every pulse lasts exactly as long as the command.
module usb_host_model
  import usb_irq_pkg::*;
(
  input  wire logic       go_i,   // Command valid in this cycle.
  input  wire logic [2:0] cmd_i,  // Event kind, decoded below.
  input  wire logic [1:0] ep_i,   // Endpoint number for packet events.
  output pkt_evt_s        pkt_o,  // Packet completion pulse.
  output bus_evt_s        bus_o   // Bus signalling pulse.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Codes 0 to 3 are packets: good receive, bad receive, acked send, unacked send.
  always_comb begin
    pkt_o.valid  = go_i && (cmd_i < 3'h4);
    pkt_o.is_in  = cmd_i[1];
    pkt_o.ep     = ep_i;
    pkt_o.crc_ok = (cmd_i != 3'h1);
    pkt_o.hs_ack = (cmd_i == 3'h2);
  end
  // Codes 4 to 7 are line events: frame start, reset, resume, suspend.
  always_comb begin
    bus_o.sof       = go_i && (cmd_i == 3'h4);
    bus_o.bus_reset = go_i && (cmd_i == 3'h5);
    bus_o.resume    = go_i && (cmd_i == 3'h6);
    bus_o.suspend   = go_i && (cmd_i == 3'h7);
  end
endmodule : usb_host_model

//--- sim/testbench.sv
// Purpose: Self-checking bench for the USB function interrupt flag block.
// Assumes: A short frame length so that synthesised frame starts come quickly.
// Notes:   Common flag reads mask bit 3 where the frame timer may have fired.
module testbench import usb_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FLEN = 50;            // Shortened frame length in cycles.
  logic       clk = 1'b0;               // Device clock.
  logic       rst = 1'b1;               // Reset, held at start.
  logic [7:0] addr = 8'h00;             // Register offset.
  logic [7:0] wdata = 8'h00;            // Write data.
  logic       wr = 1'b0;                // Write strobe.
  logic       rd = 1'b0;                // Read strobe.
  logic       go = 1'b0;                // Event command strobe.
  logic [2:0] cmd = 3'h0;               // Event kind.
  logic [1:0] ep = 2'h0;                // Event endpoint.
  logic [7:0] rdata;                    // Read data.
  logic       suspended;                // Suspend mode.
  logic       handshake;                // Handshake pulse.
  logic       irq;                      // Interrupt request.
  logic       hs;                       // Handshake seen after last event.
  pkt_evt_s   pkt;                      // Packet events.
  bus_evt_s   bus;                      // Bus events.
  int         total_checks = 0;         // Comparisons made.
  int         miscompares = 0;          // Mismatches found.
  int         cycles = 0;               // Cycle count for the hang guard.

  usb_function_irq_flags #(.FRAME_LEN(FLEN)) u_usb_function_irq_flags (
    .clk_sys_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .pkt_i(pkt), .bus_i(bus), .suspended_o(suspended),
    .handshake_o(handshake), .irq_o(irq));
  usb_host_model u_usb_host_model (.go_i(go), .cmd_i(cmd), .ep_i(ep), .pkt_o(pkt), .bus_o(bus));

  // Free-running clock, 8 ns period.
  initial begin
    forever #4 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Compares one value against its expectation.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write; returns once the written state has settled.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // One-cycle read; the data are taken in the following cycle and masked.
  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata & m, exp);
  endtask : chk

  // One-cycle event from the far side; records the handshake that follows it.
  task automatic ev(input logic [2:0] c, input logic [1:0] e);
    @(posedge clk);
    go <= 1'b1;
    cmd <= c;
    ep <= e;
    @(posedge clk);
    go <= 1'b0;
    #1;
    hs = handshake;
  endtask : ev

  // Hang guard: the sequence needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped offset and unused upper bits.
    chk(ADDR_IN_EN, 8'hFF, 8'h0F);
    chk(ADDR_OUT_EN, 8'hFF, 8'h0E);
    chk(ADDR_CM_EN, 8'hFF, 8'h06);
    chk(8'h30, 8'hFF, 8'h00);
    wr_reg(ADDR_IN_EN, 8'hF0);
    chk(ADDR_IN_EN, 8'hFF, 8'h00);
    wr_reg(ADDR_IN_EN, 8'h0F);
    wr_reg(ADDR_OUT_FLAGS, 8'hFF);
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h00);
    // Good receives on all OUT endpoints, then clear on read.
    for (int i = 1; i < 4; i++) begin
      ev(3'h0, i[1:0]);
      check({7'h00, hs}, 8'h01);
    end
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h0E);
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h00);
    // Corrupted receive and unacknowledged send leave no trace.
    ev(3'h1, 2'h2);
    check({7'h00, hs}, 8'h00);
    ev(3'h3, 2'h1);
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h00);
    chk(ADDR_IN_FLAGS, 8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ev(3'h2, i[1:0]);
    end
    chk(ADDR_IN_FLAGS, 8'hFF, 8'h0F);
    chk(ADDR_IN_FLAGS, 8'hFF, 8'h00);
    // Request follows enabled flags; a disabled flag still records.
    chk(ADDR_CM_FLAGS, 8'h07, 8'h00);
    check({7'h00, irq}, 8'h00);
    ev(3'h0, 2'h2);
    check({7'h00, irq}, 8'h01);
    wr_reg(ADDR_OUT_EN, 8'h00);
    check({7'h00, irq}, 8'h00);
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h04);
    wr_reg(ADDR_OUT_EN, 8'hFF);
    chk(ADDR_OUT_EN, 8'hFF, 8'h0E);
    // Event in the same cycle as the clearing read survives it.
    @(posedge clk);
    go <= 1'b1;
    cmd <= 3'h0;
    ep <= 2'h3;
    rd <= 1'b1;
    addr <= ADDR_OUT_FLAGS;
    @(posedge clk);
    go <= 1'b0;
    rd <= 1'b0;
    #1;
    check(rdata, 8'h00);
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h08);
    // Suspend and resume, with and without detection.
    ev(3'h7, 2'h0);
    check({7'h00, suspended}, 8'h00);
    ev(3'h6, 2'h0);
    chk(ADDR_CM_FLAGS, 8'h07, 8'h00);
    wr_reg(ADDR_CTRL, 8'h01);
    ev(3'h7, 2'h0);
    check({7'h00, suspended}, 8'h01);
    check({7'h00, irq}, 8'h00);
    chk(ADDR_CM_FLAGS, 8'h07, 8'h01);
    ev(3'h6, 2'h0);
    check({7'h00, irq}, 8'h01);
    chk(ADDR_CM_FLAGS, 8'h07, 8'h02);
    chk(ADDR_CM_FLAGS, 8'h07, 8'h00);
    check({7'h00, suspended}, 8'h00);
    // Frame start from the token, then from the own timer.
    ev(3'h4, 2'h0);
    chk(ADDR_CM_FLAGS, 8'hFF, 8'h08);
    repeat (FLEN + 10) @(posedge clk);
    chk(ADDR_CM_FLAGS, 8'hFF, 8'h08);
    // Bus reset re-arms enables and clears pending flags.
    wr_reg(ADDR_CM_EN, 8'h00);
    wr_reg(ADDR_IN_EN, 8'h00);
    wr_reg(ADDR_OUT_EN, 8'h00);
    ev(3'h0, 2'h1);
    ev(3'h5, 2'h0);
    chk(ADDR_CM_EN, 8'hFF, 8'h0E);
    chk(ADDR_IN_EN, 8'hFF, 8'h0F);
    chk(ADDR_OUT_EN, 8'hFF, 8'h0E);
    chk(ADDR_OUT_FLAGS, 8'hFF, 8'h00);
    chk(ADDR_CM_FLAGS, 8'h07, 8'h04);
    // Bus reset in the same cycle as a clearing read of the common flags.
    @(posedge clk);
    go <= 1'b1;
    cmd <= 3'h5;
    rd <= 1'b1;
    addr <= ADDR_CM_FLAGS;
    @(posedge clk);
    go <= 1'b0;
    rd <= 1'b0;
    #1;
    check(rdata & 8'h07, 8'h00);
    chk(ADDR_CM_FLAGS, 8'h07, 8'h04);
    test_done();
  end
endmodule : testbench
